// file: rtl/bank_address_expander.sv
// bank address expander: logical to physical address and extended chip selects
//
// Operation
// - four fixed local areas extend external memory to 136 Mbytes via bank numbers
// - drive two extended address bits and seven extended selects beyond base bus
// - program area c0..df, seven 2 Mbyte banks beside a common region
// - data rom area 80..bf, twenty-four 4 Mbyte banks
// - sdram area 40..5f, seven 2 Mbyte banks plus common region
// - data ram area 10..1f, seven 1 Mbyte banks plus common region
// - data rom banks served by six extended selects, 16 Mbyte each
// - logical window of every area is fixed in hardware
// - banked access puts the physical address from the bank setting on the pins
// - without bank programming the unit passes addresses through unchanged
// - after reset fetches go to the third chip select region
`timescale 1ns/1ps
module bank_address_expander (
  input  wire logic                            clk,                  // system clock
  input  wire logic                            arst_n,               // async reset, active low
  input  wire logic                            clk_en,               // freezes state when low
  input  wire logic [bank_pkg::REG_ADDR_W-1:0] reg_addr,             // register byte address
  input  wire logic [31:0]                     reg_wdata,            // register write data
  input  wire logic                            reg_wr,               // register write strobe
  input  wire logic                            reg_rd,               // register read strobe
  output logic      [31:0]                     reg_rdata,            // register read data
  input  wire logic [23:0]                     cpu_addr,             // logical address
  input  wire logic                            chip_select_first_n,  // controller select 0
  input  wire logic                            chip_select_second_n, // controller select 1
  input  wire logic                            chip_select_third_n,  // controller select 2
  input  wire logic                            chip_select_fourth_n, // controller select 3
  input  wire logic                            extra_select_region_n,// controller extra select
  output logic      [23:0]                     phys_addr,            // physical address pins
  output logic                                 ext_addr_bit_a,       // extended address bit 24
  output logic                                 ext_addr_bit_b,       // extended address bit 25
  output logic                                 cs_first_out_n,       // select 0 to memory
  output logic                                 cs_second_out_n,      // select 1 to memory
  output logic                                 cs_third_out_n,       // select 2 to memory
  output logic                                 cs_fourth_out_n,      // select 3 to memory
  output logic                                 ext_select_a_n,       // program rom select
  output logic                                 ext_select_b_n,       // data rom device 0
  output logic                                 ext_select_c_n,       // data rom device 1
  output logic                                 ext_select_d_n,       // data rom device 2
  output logic                                 ext_select_e_n,       // data rom device 3
  output logic                                 ext_select_f_n,       // data rom device 4
  output logic                                 ext_select_g_n,       // data rom device 5
  output logic                                 extra_select_out_n    // extra select to memory
);
  import bank_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] cfg_area0, cfg_area1, cfg_area2, cfg_area3;
  logic [7:0] status;

  bank_reg_file u_regs (
    .clk       (clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .status_in (status),
    .reg_rdata (reg_rdata),
    .cfg_area0 (cfg_area0),
    .cfg_area1 (cfg_area1),
    .cfg_area2 (cfg_area2),
    .cfg_area3 (cfg_area3)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  // one-hot data rom device from the top three bits of the bank number
  function automatic logic [ROM_SELECTS-1:0] rom_onehot(input logic [2:0] grp);
    rom_onehot = '0;
    if (grp <= ROM_GROUP_LAST) begin
      rom_onehot[grp] = 1'b1;
    end
  endfunction : rom_onehot

  logic [7:0]             ah;
  logic                   hit0, hit1, hit2, hit3;
  logic [23:0]            next_phys;
  logic [1:0]             next_ext;
  logic [ROM_SELECTS-1:0] next_rom_sel;
  logic                   next_sel_a;
  logic [7:0]             next_status;
  logic [3:0]             next_cs_n;
  logic                   next_extra_n;
  logic                   next_prog_n;
  logic [ROM_SELECTS-1:0] next_rom_n;

  assign ah = cpu_addr[23:16];

  // the windows are constants, nothing can move them
  always_comb begin
    hit0 = (ah[7:4] == AREA0_HI4) && cfg_area0[BANK_ENABLE_BIT];
    hit1 = (ah[7:5] == AREA1_HI3) && cfg_area1[BANK_ENABLE_BIT];
    hit2 = (ah[7:5] == AREA2_HI3) && cfg_area2[BANK_ENABLE_BIT];
    hit3 = (ah[7:6] == AREA3_HI2) && cfg_area3[BANK_ENABLE_BIT];
  end

  always_comb begin
    // default is plain pass-through, so an unprogrammed unit serves 16 Mbytes as is
    next_phys    = cpu_addr;
    next_ext     = 2'b00;
    next_rom_sel = '0;
    next_sel_a   = !chip_select_third_n;
    if (hit0) begin
      next_phys[AREA0_BANK_LSB +: 3] = cfg_area0[2:0];
    end
    if (hit1) begin
      next_phys[AREA12_BANK_LSB +: 3] = cfg_area1[2:0];
    end
    if (hit2) begin
      next_phys[AREA12_BANK_LSB +: 3] = cfg_area2[2:0];
    end
    if (hit3) begin
      // 5-bit bank spans bits 26..22; bit 26 is not brought out
      next_phys[AREA3_BANK_LSB +: 2] = cfg_area3[1:0];
      next_ext                       = cfg_area3[3:2];
      next_rom_sel                   = rom_onehot(cfg_area3[4:2]);
      next_sel_a                     = 1'b0;
    end
    next_status                     = 8'h00;
    next_status[STAT_AREA_LSB +: 4] = {hit3, hit2, hit1, hit0};
    next_status[STAT_HIT_BIT]       = hit0 | hit1 | hit2 | hit3;
    // controller selects are retimed but never gated: software keeps the whole decode
    next_cs_n    = {chip_select_fourth_n, chip_select_third_n,
                    chip_select_second_n, chip_select_first_n};
    next_extra_n = extra_select_region_n;
    next_prog_n  = !next_sel_a;
    next_rom_n   = ~next_rom_sel;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output registers

  // all pins retime together so address and selects stay aligned
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phys_addr          <= 24'h00_0000;
      ext_addr_bit_a     <= 1'b0;
      ext_addr_bit_b     <= 1'b0;
      cs_first_out_n     <= 1'b1;
      cs_second_out_n    <= 1'b1;
      cs_third_out_n     <= 1'b1;
      cs_fourth_out_n    <= 1'b1;
      ext_select_a_n     <= 1'b1;
      ext_select_b_n     <= 1'b1;
      ext_select_c_n     <= 1'b1;
      ext_select_d_n     <= 1'b1;
      ext_select_e_n     <= 1'b1;
      ext_select_f_n     <= 1'b1;
      ext_select_g_n     <= 1'b1;
      extra_select_out_n <= 1'b1;
      status             <= 8'h00;
    end else if (clk_en) begin
      phys_addr          <= next_phys;
      ext_addr_bit_a     <= next_ext[0];
      ext_addr_bit_b     <= next_ext[1];
      cs_first_out_n     <= next_cs_n[0];
      cs_second_out_n    <= next_cs_n[1];
      cs_third_out_n     <= next_cs_n[2];
      cs_fourth_out_n    <= next_cs_n[3];
      ext_select_a_n     <= next_prog_n;
      ext_select_b_n     <= next_rom_n[0];
      ext_select_c_n     <= next_rom_n[1];
      ext_select_d_n     <= next_rom_n[2];
      ext_select_e_n     <= next_rom_n[3];
      ext_select_f_n     <= next_rom_n[4];
      ext_select_g_n     <= next_rom_n[5];
      extra_select_out_n <= next_extra_n;
      status             <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [5:0] rom_pins_n;
  assign rom_pins_n = {ext_select_g_n, ext_select_f_n, ext_select_e_n,
                       ext_select_d_n, ext_select_c_n, ext_select_b_n};

  AST_PASS_THROUGH: assert property (
    clk_en && !cfg_area0[7] && !cfg_area1[7] && !cfg_area2[7] && !cfg_area3[7]
      |=> phys_addr == $past(cpu_addr) && !ext_addr_bit_a && !ext_addr_bit_b)
    else $error("unbanked address not passed through");

  AST_AREA0_MAP: assert property (
    clk_en && cpu_addr[23:20] == 4'h1 && cfg_area0[7]
      |=> phys_addr[22:20] == $past(cfg_area0[2:0]) && phys_addr[23] == 1'b0
          && phys_addr[19:0] == $past(cpu_addr[19:0]))
    else $error("data ram area bank not applied");

  AST_AREA1_MAP: assert property (
    clk_en && cpu_addr[23:21] == 3'b010 && cfg_area1[7]
      |=> phys_addr[23:21] == $past(cfg_area1[2:0]) && phys_addr[20:0] == $past(cpu_addr[20:0]))
    else $error("sdram area bank not applied");

  AST_AREA2_MAP: assert property (
    clk_en && cpu_addr[23:21] == 3'b110 && cfg_area2[7]
      |=> phys_addr[23:21] == $past(cfg_area2[2:0]))
    else $error("program area bank not applied");

  AST_AREA3_MAP: assert property (
    clk_en && cpu_addr[23:22] == 2'b10 && cfg_area3[7]
      |=> {ext_addr_bit_b, ext_addr_bit_a, phys_addr[23:22]} == $past(cfg_area3[3:0])
          && phys_addr[21:0] == $past(cpu_addr[21:0]))
    else $error("data rom area bank not applied");

  AST_ROM_SELECT: assert property (
    clk_en && cpu_addr[23:22] == 2'b10 && cfg_area3[7] && cfg_area3[4:2] == 3'h3
      |=> !ext_select_e_n && $countones(rom_pins_n) == 5 && ext_select_a_n)
    else $error("data rom select decode wrong");

  AST_ROM_NONE: assert property (
    clk_en && !(cpu_addr[23:22] == 2'b10 && cfg_area3[7] && cfg_area3[4:3] != 2'b11)
      |=> rom_pins_n == 6'h3f)
    else $error("data rom select outside a valid banked access");

  AST_THIRD_SELECT: assert property (
    clk_en && !chip_select_third_n && !(cpu_addr[23:22] == 2'b10 && cfg_area3[7])
      |=> !ext_select_a_n && !cs_third_out_n)
    else $error("third select not routed to program rom");

  AST_FREEZE: assert property (
    !clk_en |=> $stable(phys_addr) && $stable(rom_pins_n))
    else $error("state moved with clock enable low");

  AST_SELECT_FREEZE: assert property (
    !clk_en |=> $stable({ext_addr_bit_b, ext_addr_bit_a, ext_select_a_n, extra_select_out_n})
      && $stable({cs_fourth_out_n, cs_third_out_n, cs_second_out_n, cs_first_out_n}))
    else $error("select pins moved with clock enable low");

  AST_CFG_FREEZE: assert property (
    !clk_en |=> $stable({cfg_area3, cfg_area2, cfg_area1, cfg_area0}) && $stable(status))
    else $error("bank setting moved with clock enable low");

  AST_CS_RETIME: assert property (
    clk_en |=> {cs_fourth_out_n, cs_third_out_n, cs_second_out_n, cs_first_out_n}
      == $past({chip_select_fourth_n, chip_select_third_n, chip_select_second_n,
                chip_select_first_n}))
    else $error("controller select not retimed");

  AST_EXTRA_RETIME: assert property (
    clk_en |=> extra_select_out_n == $past(extra_select_region_n))
    else $error("extra select not retimed");

  AST_EXT_BITS_IDLE: assert property (
    clk_en && !(cpu_addr[23:22] == 2'b10 && cfg_area3[7])
      |=> !ext_addr_bit_a && !ext_addr_bit_b)
    else $error("extended address bits set outside a banked data rom access");

  // addresses between the windows must never be touched, whatever the bank setting
  AST_WINDOW_FIXED: assert property (
    clk_en && (cpu_addr[23:20] == 4'h0 || cpu_addr[23:21] == 3'b001
               || cpu_addr[23:21] == 3'b011 || cpu_addr[23:21] == 3'b111)
      |=> phys_addr == $past(cpu_addr))
    else $error("address outside the windows was remapped");

  AST_AREA2_OFFSET: assert property (
    clk_en && cpu_addr[23:21] == 3'b110 && cfg_area2[7]
      |=> phys_addr[20:0] == $past(cpu_addr[20:0]) && !ext_addr_bit_a && !ext_addr_bit_b)
    else $error("program area offset not passed through");

  AST_PROG_OFF: assert property (
    clk_en && (chip_select_third_n || (cpu_addr[23:22] == 2'b10 && cfg_area3[7]))
      |=> ext_select_a_n)
    else $error("program rom selected without the third select");

  // two devices answering together would fight on the data bus
  AST_ONE_DEVICE: assert property (
    $onehot0({~rom_pins_n, ~ext_select_a_n}))
    else $error("more than one rom device selected");

  AST_STATUS_ROM: assert property (
    clk_en && cpu_addr[23:22] == 2'b10 && cfg_area3[7] |=> status == 8'h18)
    else $error("status does not show a banked data rom access");

  // main scenarios the bench has to reach

  COV_AREA3_BANK: cover property (clk_en && cpu_addr[23:22] == 2'b10 && cfg_area3[7]);
  COV_AREA2_BANK: cover property (clk_en && cpu_addr[23:21] == 3'b110 && cfg_area2[7]);
  COV_AREA0_BANK: cover property (clk_en && cpu_addr[23:20] == 4'h1 && cfg_area0[7]);
  COV_ROM_LAST:   cover property (clk_en && hit3 && cfg_area3[4:2] == 3'h5);
  COV_ROM_EMPTY:  cover property (clk_en && hit3 && cfg_area3[4:3] == 2'b11);
endmodule : bank_address_expander

// file: rtl/bank_pkg.sv
// package: register map, field layout and fixed area decode of the bank address expander
package bank_pkg;
  // register indices; byte address on the register port is four times the index
  localparam logic [11:0] IDX_BANK_MAP_AREA_ZERO  = 12'h01d0;
  localparam logic [11:0] IDX_BANK_MAP_AREA_ONE   = 12'h01d1;
  localparam logic [11:0] IDX_BANK_MAP_AREA_TWO   = 12'h01d2;
  localparam logic [11:0] IDX_BANK_MAP_AREA_THREE = 12'h01d3;
  localparam logic [11:0] IDX_BANK_STATUS         = 12'h01d4;
  localparam int          REG_ADDR_W              = 12;
  localparam int          BYTE_SHIFT              = 2;

  // field layout of the four bank map registers
  localparam int         BANK_ENABLE_BIT = 7;
  localparam logic [7:0] MASK_AREA_ZERO  = 8'h87;
  localparam logic [7:0] MASK_AREA_ONE   = 8'h87;
  localparam logic [7:0] MASK_AREA_TWO   = 8'h87;
  localparam logic [7:0] MASK_AREA_THREE = 8'h9f;
  localparam logic [7:0] RESET_BANK_MAP  = 8'h00;

  // fixed logical windows, upper address byte
  localparam logic [3:0] AREA0_HI4       = 4'h1;    // 10..1f, 1 Mbyte banks
  localparam logic [2:0] AREA1_HI3       = 3'b010;  // 40..5f, 2 Mbyte banks
  localparam logic [2:0] AREA2_HI3       = 3'b110;  // c0..df, 2 Mbyte banks
  localparam logic [1:0] AREA3_HI2       = 2'b10;   // 80..bf, 4 Mbyte banks
  localparam int         AREA0_BANK_LSB  = 20;
  localparam int         AREA12_BANK_LSB = 21;
  localparam int         AREA3_BANK_LSB  = 22;

  // data rom devices behind the extended selects
  localparam int         ROM_SELECTS     = 6;
  localparam logic [2:0] ROM_GROUP_LAST  = 3'h5;

  // status register layout
  localparam int STAT_AREA_LSB = 0;
  localparam int STAT_HIT_BIT  = 4;

  function automatic logic [11:0] byte_addr(input logic [11:0] idx);
    byte_addr = {idx[9:0], 2'b00};
  endfunction : byte_addr
endpackage : bank_pkg

// file: rtl/bank_reg_file.sv
// bank map registers and status readback on the plain register port
`timescale 1ns/1ps
module bank_reg_file (
  input  wire logic                            clk,          // system clock
  input  wire logic                            arst_n,       // async reset, active low
  input  wire logic                            clk_en,       // freezes all state when low
  input  wire logic [bank_pkg::REG_ADDR_W-1:0] reg_addr,     // byte address
  input  wire logic [31:0]                     reg_wdata,    // write data, low byte used
  input  wire logic                            reg_wr,       // write strobe
  input  wire logic                            reg_rd,       // read strobe
  input  wire logic [7:0]                      status_in,    // live block state
  output logic      [31:0]                     reg_rdata,    // read data, cycle after strobe
  output logic      [7:0]                      cfg_area0,    // data ram area map
  output logic      [7:0]                      cfg_area1,    // sdram area map
  output logic      [7:0]                      cfg_area2,    // program area map
  output logic      [7:0]                      cfg_area3     // data rom area map
);
  import bank_pkg::*;

  logic [7:0]  next_area0, next_area1, next_area2, next_area3;
  logic [31:0] next_rdata;

  always_comb begin
    next_area0 = cfg_area0;
    next_area1 = cfg_area1;
    next_area2 = cfg_area2;
    next_area3 = cfg_area3;
    next_rdata = 32'h0000_0000;
    if (reg_wr) begin
      // reserved bits never store, so they read back as zero
      case (reg_addr)
        byte_addr(IDX_BANK_MAP_AREA_ZERO):  next_area0 = reg_wdata[7:0] & MASK_AREA_ZERO;
        byte_addr(IDX_BANK_MAP_AREA_ONE):   next_area1 = reg_wdata[7:0] & MASK_AREA_ONE;
        byte_addr(IDX_BANK_MAP_AREA_TWO):   next_area2 = reg_wdata[7:0] & MASK_AREA_TWO;
        byte_addr(IDX_BANK_MAP_AREA_THREE): next_area3 = reg_wdata[7:0] & MASK_AREA_THREE;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        byte_addr(IDX_BANK_MAP_AREA_ZERO):  next_rdata = {24'h00_0000, cfg_area0};
        byte_addr(IDX_BANK_MAP_AREA_ONE):   next_rdata = {24'h00_0000, cfg_area1};
        byte_addr(IDX_BANK_MAP_AREA_TWO):   next_rdata = {24'h00_0000, cfg_area2};
        byte_addr(IDX_BANK_MAP_AREA_THREE): next_rdata = {24'h00_0000, cfg_area3};
        byte_addr(IDX_BANK_STATUS):         next_rdata = {24'h00_0000, status_in};
        default:                            next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_area0 <= RESET_BANK_MAP;
      cfg_area1 <= RESET_BANK_MAP;
      cfg_area2 <= RESET_BANK_MAP;
      cfg_area3 <= RESET_BANK_MAP;
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      cfg_area0 <= next_area0;
      cfg_area1 <= next_area1;
      cfg_area2 <= next_area2;
      cfg_area3 <= next_area3;
      reg_rdata <= next_rdata;
    end
  end

  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && reg_rd && reg_addr == byte_addr(IDX_BANK_MAP_AREA_ONE)
      |=> reg_rdata[31:8] == 24'h00_0000 && reg_rdata[6:3] == 4'h0)
    else $error("reserved bits of a bank map register read non-zero");
endmodule : bank_reg_file

// file: tb/ext_memory_model.sv
// external memory side: rebuilds the device address and counts active rom selects
`timescale 1ns/1ps
module ext_memory_model (
  input  wire logic [23:0] phys_addr,      // address pins
  input  wire logic        ext_addr_bit_a, // address bit 24
  input  wire logic        ext_addr_bit_b, // address bit 25
  input  wire logic [5:0]  rom_sel_n,      // data rom device selects
  input  wire logic        prog_sel_n,     // program rom select
  output logic      [25:0] dev_addr,       // byte address seen by the memories
  output logic      [24:0] dev_word,       // word address of a 16-bit device
  output logic      [3:0]  dev_hits        // rom devices answering at once
);
  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    dev_addr = {ext_addr_bit_b, ext_addr_bit_a, phys_addr};
    // 16-bit parts are wired one line up, so they never see bit 0
    dev_word = dev_addr[25:1];
    // two rom devices driving the bus at once would be a contention fault
    dev_hits = {3'h0, ~prog_sel_n};
    for (int i = 0; i < 6; i++) begin
      dev_hits = dev_hits + {3'h0, ~rom_sel_n[i]};
    end
  end
endmodule : ext_memory_model

// file: tb/bank_address_expander_tb_top.sv
// testbench: register port, logical to physical mapping and select decode
`timescale 1ns/1ps
module bank_address_expander_tb_top;
  import bank_pkg::*;
  logic        clk        = 1'b0;
  logic        arst_n     = 1'b0;
  logic        clk_en     = 1'b1;
  logic [11:0] reg_addr   = 12'h000;
  logic [31:0] reg_wdata  = 32'h0000_0000;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [23:0] cpu_addr   = 24'h00_0000;
  logic [4:0]  ctl_n      = 5'h1f;
  logic [31:0] reg_rdata;
  logic [23:0] phys_addr;
  logic        ext_a;
  logic        ext_b;
  logic [4:0]  cs_out_n;
  logic [5:0]  rom_sel_n;
  logic        prog_sel_n;
  logic [25:0] dev_addr;
  logic [24:0] dev_word;
  logic [3:0]  dev_hits;
  logic [7:0]  sh [4]     = '{default: 8'h00};
  int          errors     = 0;
  int          num_checks = 0;
  localparam logic [23:0] PROBE [13] = '{24'h10_0000, 24'h1f_fffe, 24'h0f_ffff, 24'h20_0000,
    24'h3f_0000, 24'h40_0000, 24'h5f_ffff, 24'h60_0000, 24'h80_0000, 24'hbf_ffff,
    24'hc0_0000, 24'hdf_ffff, 24'he0_0000};

  always #2 clk = ~clk;

  bank_address_expander dut (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_addr(cpu_addr), .chip_select_first_n(ctl_n[0]), .chip_select_second_n(ctl_n[1]),
    .chip_select_third_n(ctl_n[2]), .chip_select_fourth_n(ctl_n[3]),
    .extra_select_region_n(ctl_n[4]), .phys_addr(phys_addr), .ext_addr_bit_a(ext_a),
    .ext_addr_bit_b(ext_b), .cs_first_out_n(cs_out_n[0]), .cs_second_out_n(cs_out_n[1]),
    .cs_third_out_n(cs_out_n[2]), .cs_fourth_out_n(cs_out_n[3]),
    .ext_select_a_n(prog_sel_n), .ext_select_b_n(rom_sel_n[0]), .ext_select_c_n(rom_sel_n[1]),
    .ext_select_d_n(rom_sel_n[2]), .ext_select_e_n(rom_sel_n[3]),
    .ext_select_f_n(rom_sel_n[4]), .ext_select_g_n(rom_sel_n[5]),
    .extra_select_out_n(cs_out_n[4]));

  ext_memory_model mem (
    .phys_addr(phys_addr), .ext_addr_bit_a(ext_a), .ext_addr_bit_b(ext_b),
    .rom_sel_n(rom_sel_n), .prog_sel_n(prog_sel_n), .dev_addr(dev_addr),
    .dev_word(dev_word), .dev_hits(dev_hits));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // memory controller stand-in: the select map software is told to program
  function automatic logic [4:0] ctl_map(input logic [23:0] a);
    ctl_map = 5'h1f;
    if (a[23]) ctl_map[2] = 1'b0;
    else if (a[23:22] == 2'b01) ctl_map[1] = 1'b0;
    else if (a[23:21] == 3'b000) ctl_map[3] = 1'b0;
    else if (a[23:20] == 4'h2) ctl_map[0] = 1'b0;
    else ctl_map[4] = 1'b0;
  endfunction : ctl_map

  // {banked rom hit, rom select group, 26-bit physical address}
  function automatic logic [29:0] expect_map(input logic [23:0] a);
    logic [25:0] p;
    logic [2:0]  g;
    logic        rb;
    p  = {2'b00, a};
    g  = 3'h7;
    rb = 1'b0;
    if (a[23:20] == 4'h1 && sh[0][7]) p[22:20] = sh[0][2:0];
    else if (a[23:21] == 3'b010 && sh[1][7]) p[23:21] = sh[1][2:0];
    else if (a[23:21] == 3'b110 && sh[2][7]) p[23:21] = sh[2][2:0];
    else if (a[23:22] == 2'b10 && sh[3][7]) begin
      p[25:22] = sh[3][3:0];
      g        = sh[3][4:2];
      rb       = 1'b1;
    end
    expect_map = {rb, g, p};
  endfunction : expect_map

  //////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= {24'h00_0000, d};
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a[11:4] == 8'h74) sh[a[3:2]] = d & ((a[3:2] == 2'd3) ? MASK_AREA_THREE : MASK_AREA_ZERO);
  endtask : reg_write

  task automatic reg_read(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp, what);
  endtask : reg_read

  // one cpu cycle through the pins; the answer lands one enabled edge later
  task automatic access(input logic [23:0] a);
    logic [29:0] e;
    logic [4:0]  c;
    logic [5:0]  rs;
    logic        pa;
    e  = expect_map(a);
    c  = ctl_map(a);
    rs = ~(6'h01 << e[28:26]);
    pa = e[29] ? 1'b1 : c[2];
    @(posedge clk);
    cpu_addr <= a;
    ctl_n    <= c;
    @(posedge clk);
    #1 check(dev_addr, e[25:0], "physical address");
    check(dev_word, e[25:1], "word address");
    check(rom_sel_n, rs, "rom selects");
    check(prog_sel_n, pa, "program select");
    check(cs_out_n, c, "controller selects");
    check(dev_hits, {3'h0, e[28:26] < 3'h6} + {3'h0, ~pa}, "select overlap");
  endtask : access

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 4; i++) reg_read(12'h740 + 12'(4 * i), 32'h0000_0000, "reset");
    reg_read(12'h760, 32'h0000_0000, "unmapped read");
    access(24'hff_0000);
    access(24'hc3_4567);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      reg_write(12'h740 + 12'(4 * i), 8'hff);
      reg_read(12'h740 + 12'(4 * i), {24'h00_0000, sh[i]}, "field mask");
    end
    reg_write(12'h760, 8'h55);
    reg_read(12'h760, 32'h0000_0000, "unmapped write");
    $display("test registers done");
  endtask : t_regs

  task automatic t_areas();
    reg_write(12'h740, 8'h83);
    reg_write(12'h744, 8'h84);
    reg_write(12'h748, 8'h81);
    reg_write(12'h74c, 8'h85);
    foreach (PROBE[i]) access(PROBE[i]);
    access(24'h80_0000);
    reg_read(12'h750, 32'h0000_0018, "status");
    $display("test areas done");
  endtask : t_areas

  task automatic t_rom();
    for (int k = 0; k < 32; k++) begin
      access(24'he1_0000);
      reg_write(12'h74c, 8'h80 | 8'(k));
      access(24'h81_2345);
    end
    access(24'hbf_fffe);
    $display("test rom banks done");
  endtask : t_rom

  task automatic t_disable();
    for (int i = 0; i < 4; i++) reg_write(12'h740 + 12'(4 * i), 8'h07);
    foreach (PROBE[i]) access(PROBE[i]);
    $display("test disabled done");
  endtask : t_disable

  task automatic t_hold();
    access(24'h41_0000);
    @(posedge clk);
    clk_en    <= 1'b0;
    cpu_addr  <= 24'hc1_0000;
    reg_addr  <= 12'h740;
    reg_wdata <= 32'h0000_0085;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
    clk_en <= 1'b1;
    #1 check(phys_addr, 24'h41_0000, "held address");
    reg_read(12'h740, {24'h00_0000, sh[0]}, "frozen write");
    $display("test hold done");
  endtask : t_hold

  initial begin
    #200000;
    errors++;
    $display("wrong value at %0t ns: run limit reached", $time);
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_areas();
    t_rom();
    t_disable();
    t_hold();
    tally_and_finish();
  end
endmodule : bank_address_expander_tb_top
